// ### rtl/ctm_pkg.sv
// package for the compact timer: register map, field layout, modes, reset values
// assumes a byte-wide register port with byte offsets of our choosing
package ctm_pkg;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNT_LO = 3'h2;
  localparam logic [2:0] OFS_CNT_HI = 3'h3;
  localparam logic [2:0] OFS_CMPA_LO = 3'h4;
  localparam logic [2:0] OFS_CMPA_HI = 3'h5;
  localparam logic [2:0] OFS_FLAGS = 3'h6;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] CMPA_RST = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [2:0] PCODE_ZERO = 3'h0;
  localparam int unsigned PCODE_LSB = 7;
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] OF_NONE = 2'h0;
  localparam logic [1:0] OF_LOW = 2'h1;
  localparam logic [1:0] OF_HIGH = 2'h2;
  localparam logic [1:0] OF_TOGGLE = 2'h3;
  localparam logic [1:0] PF_INACTIVE = 2'h0;
  localparam logic [1:0] PF_ACTIVE = 2'h1;
  localparam logic [1:0] PF_WAVE = 2'h2;
  // control 0: pause, clock select(unused), on/off, period code
  typedef struct packed {
    logic counter_pause;
    logic [2:0] clk_sel;
    logic timer_on_off;
    logic [2:0] period_code;
  } ctm_ctrl0_t;
  // control 1 layout
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] out_func;
    logic output_control;
    logic output_invert;
    logic period_duty_swap;
    logic clear_select;
  } ctm_ctrl1_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ctm_bus_t;
  typedef struct packed {
    logic a_match;
    logic p_match;
  } ctm_match_t;
endpackage : ctm_pkg

// ### rtl/ctm_match.sv
// comparators A and P against the counter
// assumes counter and compare values from the timer core
`timescale 1ns/10ps
`default_nettype none
module ctm_match (
  input wire logic [9:0] count_i,
  input wire logic [9:0] cmpa_i,
  input wire logic [2:0] pcode_i,
  output ctm_pkg::ctm_match_t match_o
);
  // p compares only counter bits 9..7
  always_comb begin
    match_o.a_match = (count_i == cmpa_i);
    match_o.p_match = (count_i[9:ctm_pkg::PCODE_LSB] == pcode_i);
  end
endmodule // ctm_match
`default_nettype wire

// ### rtl/ctm_regs.sv
// control register storage and sw flag clear decode
// assumes one-cycle write strobes
`timescale 1ns/10ps
`default_nettype none
module ctm_regs (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire ctm_pkg::ctm_bus_t bus_i,
  output ctm_pkg::ctm_ctrl0_t ctrl0_o,
  output ctm_pkg::ctm_ctrl1_t ctrl1_o,
  output logic [9:0] cmpa_o,
  output logic [1:0] flag_clr_o
);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl0_o <= ctm_pkg::CTRL0_RST;
      ctrl1_o <= ctm_pkg::CTRL1_RST;
    end else if (bus_i.wr && bus_i.addr == ctm_pkg::OFS_CTRL0) begin
      ctrl0_o <= bus_i.wdata;
    end else if (bus_i.wr && bus_i.addr == ctm_pkg::OFS_CTRL1) begin
      ctrl1_o <= bus_i.wdata;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmpa_o <= ctm_pkg::CMPA_RST;
    end else if (bus_i.wr && bus_i.addr == ctm_pkg::OFS_CMPA_LO) begin
      cmpa_o[7:0] <= bus_i.wdata;
    end else if (bus_i.wr && bus_i.addr == ctm_pkg::OFS_CMPA_HI) begin
      cmpa_o[9:8] <= bus_i.wdata[1:0];
    end
  end
  // write one to clear
  always_comb begin
    flag_clr_o = (bus_i.wr && bus_i.addr == ctm_pkg::OFS_FLAGS) ? bus_i.wdata[1:0] : 2'h0;
  end
endmodule // ctm_regs
`default_nettype wire

// ### rtl/ctm_top.sv
// compact 10-bit timer: counter, two comparators, output pin and flags
// assumes synchronous byte register port and one system clock used as counter clock
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - counter readable as low byte plus bits nine and eight; rest zero
// - compare A value read/write as low byte and two-bit high byte
// - mode field: 00 compare output, 10 pwm, 11 timer/counter
// - clear select low: clear on P match or overflow at code zero; both flags
// - clear select high: clear on A match, only A flag raised
// - clear select high with A zero: overflow at 3ff, no A flag
// - compare mode pin changes only on A match and on enable rising edge
// - output function: none, low, high or toggle on A match
// - enable rising edge loads pin with output-control initial level
// - timer mode counts like compare mode, pin left unused
// - pwm ignores clear select; swap bit picks period and duty source
// - swap zero: period from code, 128 steps, zero means 1024; duty from A
// - swap one: period from A; duty from code in 128 steps, zero 1024
// - duty at or above period gives full duty
// - pwm raises a flag per comparator on match
// - pwm: output control sets active level, function forces, invert flips
// - pwm counting and flags continue while pin is forced
// - enable rising edge clears counter; falling edge keeps value
// - period code compares counter bits nine to seven
// - pwm function: 00 inactive, 01 active, 10 waveform, 11 undefined
// - pause holds counter, resumes from held value
module ctm_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic timer_output_pin_o,
  output logic timer_output_en_o,
  output logic a_match_irq_o,
  output logic p_match_irq_o
);
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b100
  } ctm_state_t;

  ctm_pkg::ctm_bus_t bus;
  ctm_pkg::ctm_ctrl0_t ctrl0;
  ctm_pkg::ctm_ctrl1_t ctrl1;
  ctm_pkg::ctm_match_t match;
  logic [9:0] cmpa;
  logic [1:0] flag_clr;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic on_d_r;
  logic on_rise;
  logic pin_r;
  logic pin_nxt;
  logic a_flag_r;
  logic p_flag_r;
  logic set_a;
  logic set_p;
  logic clear_cnt;
  logic counting;
  logic is_pwm;
  logic is_cmp;
  logic [10:0] period_val;
  logic [10:0] duty_val;
  logic wave_act;
  logic pwm_lvl;
  logic a_hit;
  logic p_hit;
  ctm_state_t state_r;
  ctm_state_t state_nxt;

  always_comb begin
    bus.wr = wr_i;
    bus.rd = rd_i;
    bus.addr = addr_i;
    bus.wdata = wdata_i;
  end

  ctm_regs u_regs (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .bus_i(bus),
    .ctrl0_o(ctrl0),
    .ctrl1_o(ctrl1),
    .cmpa_o(cmpa),
    .flag_clr_o(flag_clr)
  );

  ctm_match u_match (
    .count_i(cnt_r),
    .cmpa_i(cmpa),
    .pcode_i(ctrl0.period_code),
    .match_o(match)
  );

  // enable edge detect
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= ctrl0.timer_on_off;
    end
  end
  assign on_rise = ctrl0.timer_on_off && !on_d_r;

  // on/off sequencing
  always_comb begin
    case (state_r)
      ST_OFF: state_nxt = on_rise ? ST_START : ST_OFF;
      ST_START: state_nxt = ctrl0.timer_on_off ? ST_RUN : ST_OFF;
      ST_RUN: state_nxt = ctrl0.timer_on_off ? ST_RUN : ST_OFF;
      default: state_nxt = ST_OFF;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign is_pwm = (ctrl1.mode == ctm_pkg::MODE_PWM);
  assign is_cmp = (ctrl1.mode == ctm_pkg::MODE_CMP);
  assign counting = (state_r == ST_RUN) && !ctrl0.counter_pause;

  // pwm period and duty in counts; code zero means 1024
  always_comb begin
    if (!ctrl1.period_duty_swap) begin
      period_val = {ctrl0.period_code == ctm_pkg::PCODE_ZERO,
                    ctrl0.period_code, 7'h00};
      duty_val = {1'b0, cmpa};
    end else begin
      period_val = {1'b0, cmpa};
      duty_val = {ctrl0.period_code == ctm_pkg::PCODE_ZERO,
                  ctrl0.period_code, 7'h00};
    end
  end

  // match events on the count just reached
  always_comb begin
    a_hit = match.a_match && (cmpa != ctm_pkg::CNT_ZERO);
    p_hit = match.p_match && (cnt_r[6:0] == 7'h00) &&
            (ctrl0.period_code != ctm_pkg::PCODE_ZERO);
    set_a = 1'b0;
    set_p = 1'b0;
    clear_cnt = 1'b0;
    if (counting) begin
      if (is_pwm) begin
        // period comparator matches on the last count before the clear
        clear_cnt = ({1'b0, cnt_r} + 11'h001 >= period_val);
        if (ctrl1.period_duty_swap) begin
          set_a = clear_cnt;
          set_p = p_hit || (ctrl0.period_code == ctm_pkg::PCODE_ZERO &&
                  cnt_r == ctm_pkg::CNT_ZERO);
        end else begin
          set_a = match.a_match;
          set_p = clear_cnt;
        end
      end else if (ctrl1.clear_select) begin
        set_a = a_hit;
        clear_cnt = a_hit || (cnt_r == ctm_pkg::CNT_MAX);
      end else begin
        set_a = a_hit;
        set_p = p_hit || (ctrl0.period_code == ctm_pkg::PCODE_ZERO &&
                cnt_r == ctm_pkg::CNT_MAX);
        clear_cnt = p_hit || (cnt_r == ctm_pkg::CNT_MAX);
      end
    end
  end

  // counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (state_r == ST_START) begin
      cnt_nxt = ctm_pkg::CNT_ZERO;
    end else if (counting) begin
      cnt_nxt = clear_cnt ? ctm_pkg::CNT_ZERO : cnt_r + 10'h001;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r <= ctm_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      a_flag_r <= 1'b0;
      p_flag_r <= 1'b0;
    end else begin
      a_flag_r <= set_a || (a_flag_r && !flag_clr[1]);
      p_flag_r <= set_p || (p_flag_r && !flag_clr[0]);
    end
  end

  // pwm level before polarity
  always_comb begin
    wave_act = ({1'b0, cnt_r} < duty_val) || (duty_val >= period_val);
    case (ctrl1.out_func)
      ctm_pkg::PF_INACTIVE: pwm_lvl = !ctrl1.output_control;
      ctm_pkg::PF_ACTIVE: pwm_lvl = ctrl1.output_control;
      ctm_pkg::PF_WAVE: pwm_lvl = wave_act ? ctrl1.output_control
                                           : !ctrl1.output_control;
      default: pwm_lvl = pin_r;
    endcase
  end

  // pin level, stored before inversion
  always_comb begin
    pin_nxt = pin_r;
    if (state_r == ST_START) begin
      pin_nxt = ctrl1.output_control;
    end else if (is_pwm && state_r == ST_RUN) begin
      pin_nxt = pwm_lvl;
    end else if (is_cmp && set_a) begin
      case (ctrl1.out_func)
        ctm_pkg::OF_NONE: pin_nxt = pin_r;
        ctm_pkg::OF_LOW: pin_nxt = 1'b0;
        ctm_pkg::OF_HIGH: pin_nxt = 1'b1;
        ctm_pkg::OF_TOGGLE: pin_nxt = !pin_r;
        default: pin_nxt = pin_r;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer_output_pin_o <= 1'b0;
      timer_output_en_o <= 1'b0;
    end else begin
      timer_output_pin_o <= pin_nxt ^ ctrl1.output_invert;
      timer_output_en_o <= (ctrl1.mode != ctm_pkg::MODE_TMR) &&
                           (ctrl1.mode != 2'h1);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      a_match_irq_o <= 1'b0;
      p_match_irq_o <= 1'b0;
    end else begin
      a_match_irq_o <= set_a || (a_flag_r && !flag_clr[1]);
      p_match_irq_o <= set_p || (p_flag_r && !flag_clr[0]);
    end
  end

  // read data, one cycle after strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ctm_pkg::OFS_CTRL0: rdata_o <= ctrl0;
        ctm_pkg::OFS_CTRL1: rdata_o <= ctrl1;
        ctm_pkg::OFS_CNT_LO: rdata_o <= cnt_r[7:0];
        ctm_pkg::OFS_CNT_HI: rdata_o <= {6'h00, cnt_r[9:8]};
        ctm_pkg::OFS_CMPA_LO: rdata_o <= cmpa[7:0];
        ctm_pkg::OFS_CMPA_HI: rdata_o <= {6'h00, cmpa[9:8]};
        ctm_pkg::OFS_FLAGS: rdata_o <= {6'h00, a_flag_r, p_flag_r};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // ctm_top
`default_nettype wire

// ### test/ctm_properties.sv
// assertions on the compact timer ports
// assumes a bind into ctm_top
`timescale 1ns/10ps
`default_nettype none
module ctm_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_en_o,
  input wire logic a_match_irq_o,
  input wire logic p_match_irq_o
);
  ctm_pkg::ctm_ctrl0_t c0_r;
  ctm_pkg::ctm_ctrl1_t c1_r;
  logic [2:0] quiet_r;
  logic clr_a;
  logic calm;
  assign clr_a = wr_i && addr_i == ctm_pkg::OFS_FLAGS && wdata_i[1];
  assign calm = quiet_r == 3'h7;
  // control shadow, calm once settled
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      c0_r <= '0;
      c1_r <= '0;
      quiet_r <= 3'h0;
    end else if (wr_i && addr_i == ctm_pkg::OFS_CTRL0) begin
      c0_r <= wdata_i;
      quiet_r <= 3'h0;
    end else if (wr_i && addr_i == ctm_pkg::OFS_CTRL1) begin
      c1_r <= wdata_i;
      quiet_r <= 3'h0;
    end else if (!calm) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  read_idle_a: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata not idle");
  cnt_high_a: assert property (
    rd_i && addr_i == ctm_pkg::OFS_CNT_HI |=> rdata_o[7:2] == 6'h00) else $error("cnt high");
  cmpa_high_a: assert property (
    rd_i && addr_i == ctm_pkg::OFS_CMPA_HI |=> rdata_o[7:2] == 6'h00) else $error("cmpa high");
  pin_free_a: assert property (
    calm && c1_r.mode == ctm_pkg::MODE_TMR |-> !timer_output_en_o) else $error("pin not free");
  flag_hold_a: assert property (
    $fell(a_match_irq_o) |-> $past(clr_a) || $past(clr_a, 2)) else $error("a flag lost");
  no_p_flag_a: assert property (
    calm && c1_r.clear_select && c1_r.mode != ctm_pkg::MODE_PWM |-> !$rose(p_match_irq_o))
    else $error("p flag raised");
  pin_none_a: assert property (
    calm && c1_r.mode == ctm_pkg::MODE_CMP && c1_r.out_func == ctm_pkg::OF_NONE
    |=> $stable(timer_output_pin_o)) else $error("pin moved");
  pwm_forced_a: assert property (
    calm && c0_r.timer_on_off && c1_r.mode == ctm_pkg::MODE_PWM && c1_r.out_func[1] == 1'b0
    |-> timer_output_pin_o == (c1_r.output_control ^ c1_r.output_invert ^ !c1_r.out_func[0]))
    else $error("forced level");
endmodule // ctm_properties
bind ctm_top ctm_properties u_props (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .timer_output_pin_o, .timer_output_en_o, .a_match_irq_o, .p_match_irq_o);
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the compact timer
// assumes ctm_top and the register map of ctm_pkg
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys_i, rst_i, wr_i, rd_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d, q;
  logic timer_output_pin_o, timer_output_en_o, a_match_irq_o, p_match_irq_o;
  int error_cnt = 0;
  int total_checks = 0;
  ctm_top u_dut (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .timer_output_pin_o, .timer_output_en_o, .a_match_irq_o, .p_match_irq_o);
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // read; an expectation of 3ff means no compare
  task automatic rd(input logic [2:0] a, input logic [9:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    if (e !== 10'h3ff) chk("rdata", e, {2'h0, d});
  endtask
  task automatic seta(input logic [9:0] a);
    wr(ctm_pkg::OFS_CMPA_LO, a[7:0]);
    wr(ctm_pkg::OFS_CMPA_HI, {6'h00, a[9:8]});
  endtask
  task automatic start(input logic [2:0] pc);
    wr(ctm_pkg::OFS_CTRL0, {5'h00, pc});
    wr(ctm_pkg::OFS_FLAGS, 8'h03);
    wr(ctm_pkg::OFS_CTRL0, {5'h01, pc});
  endtask
  task automatic wait_irq(input logic p);
    logic hit = 1'b0;
    for (int i = 0; i < 1200 && hit !== 1'b1; i++) begin
      tick();
      hit = p ? p_match_irq_o : a_match_irq_o;
    end
    chk("irq", 10'h001, {9'h000, hit});
    if (hit !== 1'b1) stop_test();
  endtask
  task automatic span(input logic v, output int n);
    n = 0;
    while (timer_output_pin_o === v) begin
      tick();
      n++;
      if (n > 1100) begin
        chk("span", 10'h000, 10'h001);
        stop_test();
      end
    end
  endtask
  // pwm setup, then active and idle run lengths
  task automatic wave(input logic [9:0] a, input logic [3:0] c, input logic [2:0] pc,
                      input logic v, input logic [9:0] e1, input logic [9:0] e2);
    int n1;
    int n2;
    seta(a);
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_PWM, ctm_pkg::PF_WAVE, c});
    start(pc);
    repeat (3) tick();
    span(v, n1);
    span(!v, n1);
    span(v, n1);
    span(!v, n2);
    chk("active_run", e1, n1[9:0]);
    chk("idle_run", e2, n2[9:0]);
  endtask
  task automatic ones(input logic [9:0] e);
    int n = 0;
    repeat (4) tick();
    repeat (300) begin
      tick();
      n += timer_output_pin_o;
    end
    chk("ones", e, n[9:0]);
  endtask
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int o = 2; o < 8; o++) rd(o[2:0], 10'h000);
    wr(3'h7, 8'h5a);
    rd(3'h7, 10'h000);
    seta(10'h3ff);
    rd(ctm_pkg::OFS_CMPA_LO, 10'h0ff);
    rd(ctm_pkg::OFS_CMPA_HI, 10'h003);
    seta(10'h00a);
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_CMP, ctm_pkg::OF_HIGH, 4'h1});
    start(3'h1);
    wait_irq(1'b0);
    chk("pin", 10'h001, {9'h000, timer_output_pin_o});
    chk("pin_en", 10'h001, {9'h000, timer_output_en_o});
    start(3'h1);
    tick();
    tick();
    chk("pin", 10'h000, {9'h000, timer_output_pin_o});
    wr(ctm_pkg::OFS_CTRL0, 8'h89);
    rd(ctm_pkg::OFS_CNT_LO, 10'h3ff);
    q = d;
    repeat (25) tick();
    rd(ctm_pkg::OFS_CNT_LO, {2'h0, q});
    seta(10'h000);
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_CMP, ctm_pkg::OF_NONE, 4'h1});
    start(3'h1);
    repeat (1100) tick();
    chk("a_irq", 10'h000, {9'h000, a_match_irq_o});
    chk("p_irq", 10'h000, {9'h000, p_match_irq_o});
    seta(10'h00a);
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_CMP, ctm_pkg::OF_TOGGLE, 4'h8});
    start(3'h1);
    wait_irq(1'b1);
    chk("a_irq", 10'h001, {9'h000, a_match_irq_o});
    chk("pin", 10'h000, {9'h000, timer_output_pin_o});
    repeat (200) tick();
    rd(ctm_pkg::OFS_CNT_HI, 10'h000);
    wr(ctm_pkg::OFS_CTRL0, 8'h00);
    chk("p_irq", 10'h001, {9'h000, p_match_irq_o});
    wr(ctm_pkg::OFS_FLAGS, 8'h03);
    tick();
    chk("p_irq", 10'h000, {9'h000, p_match_irq_o});
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_TMR, ctm_pkg::OF_TOGGLE, 4'h1});
    start(3'h1);
    wait_irq(1'b0);
    chk("pin_en", 10'h000, {9'h000, timer_output_en_o});
    wave(10'h020, 4'h9, 3'h1, 1'b1, 10'd32, 10'd96);
    wave(10'h020, 4'hc, 3'h1, 1'b0, 10'd32, 10'd96);
    wave(10'h12c, 4'ha, 3'h1, 1'b1, 10'd128, 10'd172);
    wave(10'h200, 4'h8, 3'h0, 1'b1, 10'd512, 10'd512);
    seta(10'h0c8);
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_PWM, ctm_pkg::PF_WAVE, 4'h8});
    start(3'h1);
    ones(10'd300);
    chk("a_irq", 10'h000, {9'h000, a_match_irq_o});
    chk("p_irq", 10'h001, {9'h000, p_match_irq_o});
    seta(10'h040);
    wr(ctm_pkg::OFS_CTRL1, {ctm_pkg::MODE_PWM, ctm_pkg::PF_ACTIVE, 4'h0});
    start(3'h1);
    wait_irq(1'b0);
    wait_irq(1'b1);
    ones(10'd0);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
